// ==== dsx_defs.svh ====
`ifndef DSX_DEFS_SVH
`define DSX_DEFS_SVH

// Major opcode values, bits 31..26; coprocessor group by bits 31..28 only
`define DSX_MAJ_THIRD      6'h1f
`define DSX_MAJ_REGISTER_IMMEDIATE_MAJOR_OPCODE     6'h01
`define DSX_MAJ_COP_HI     4'h4

// Function field rows, bits 5..3
`define DSX_ROW_MISC       3'h1
`define DSX_ROW_ARITH      3'h2
`define DSX_ROW_HALVE      3'h3
`define DSX_ROW_FOREIGN    3'h4
`define DSX_ROW_RSV        3'h5
`define DSX_ROW_DOT        3'h6
`define DSX_ROW_EXTR       3'h7

// Debug-support slot in the function field
`define DSX_FN_DEBUG       6'h3f

// Register-immediate target field, branch slots
`define DSX_RT_BPOS_ROW    2'h3
`define DSX_RT_BPOS32      3'h4
`define DSX_RT_BPOS64      3'h5

// Register byte offsets
`define DSX_OFS_CONFIG     4'h0
`define DSX_OFS_STATUS     4'h4
`define DSX_OFS_MASK       4'h8
`define DSX_OFS_FAULT      4'hc

// Config fields
`define DSX_CFG_REL2       0
`define DSX_CFG_EXT        1
`define DSX_CFG_DEBUG      2
`define DSX_CFG_CU_LSB     4
`define DSX_CFG_WIDTH      8
`define DSX_CFG_RESET      8'h13

// Status / mask fields
`define DSX_ST_RSV         0
`define DSX_ST_CPU         1
`define DSX_ST_DSP         2
`define DSX_ST_WIDTH       3
`define DSX_MASK_RESET     3'h0

`endif

// ==== dsx_pkg.sv ====
package dsx_pkg;

   typedef enum {
      dsx_sc_indexed_load,
      dsx_sc_variable_bit_insert_word,
      dsx_sc_variable_bit_insert_doubleword,
      dsx_sc_quad_byte_add,
      dsx_sc_quad_byte_compare,
      dsx_sc_paired_half_absolute,
      dsx_sc_quad_byte_shift,
      dsx_sc_octal_byte_add,
      dsx_sc_octal_byte_compare,
      dsx_sc_quad_half_absolute,
      dsx_sc_octal_byte_shift,
      dsx_sc_halving_add,
      dsx_sc_word_dot_product,
      dsx_sc_append,
      dsx_sc_doubleword_dot_product,
      dsx_sc_word_accumulator_extract,
      dsx_sc_doubleword_accumulator_extract,
      dsx_sc_branch_position_at_least_32,
      dsx_sc_branch_position_at_least_64,
      dsx_sc_debug_support,
      dsx_sc_count
   } dsx_subclass_t;

   localparam int DSX_NSC = 20;

   typedef logic [DSX_NSC-1:0] dsx_sel_t;

   // Decode result handed to the pipeline
   typedef struct packed {
      dsx_sel_t   sel;
      logic [4:0] subclass_selector_field;
      logic       needs_op;
      logic       is_dsp;
      logic       rsv;
      logic       cop_unusable;
   } dsx_dec_t;

   // Avalon-MM request from the master
   typedef struct packed {
      logic        read;
      logic        write;
      logic [3:0]  address;
      logic [31:0] writedata;
   } dsx_avs_req_t;

endpackage

// ==== dsx_fn_decode.sv ====
`timescale 1ns/1ps
`include "dsx_defs.svh"

module dsx_fn_decode
   import dsx_pkg::*;
(
   // Function field and options
   input  wire logic [5:0]       func,
   input  wire logic             debug_present,
   // Decode
   output dsx_pkg::dsx_sel_t     sel,
   output logic                  field_class,
   output logic                  reserved,
   output logic                  owned
);

   typedef struct packed {
      dsx_sel_t sel;
      logic     fc;
      logic     rsv;
      logic     own;
   } dsx_fn_t;

   function automatic dsx_sel_t bit_of(input dsx_subclass_t sc);
      dsx_sel_t s;
      s = '0;
      s[sc] = 1'b1;
      return s;
   endfunction

   // Row selects by bits 5..3, column by bits 2..0
   function automatic dsx_fn_t decode_fn(input logic [5:0] f, input logic dbg);
      dsx_fn_t r;
      logic [2:0] lo;
      r  = '0;
      lo = f[2:0];
      unique case (f[5:3])
         `DSX_ROW_MISC: begin
            if (lo == 3'h2) begin
               r.sel = bit_of(dsx_sc_indexed_load);
               r.fc  = 1'b1;
            end else if (lo == 3'h4) begin
               r.sel = bit_of(dsx_sc_variable_bit_insert_word);
            end else if (lo == 3'h5) begin
               r.sel = bit_of(dsx_sc_variable_bit_insert_doubleword);
            end else if (lo == 3'h3 || lo >= 3'h6) begin
               r.rsv = 1'b1;
            end
            r.own = (lo >= 3'h2);
         end
         `DSX_ROW_ARITH: begin
            r.sel = bit_of(dsx_subclass_t'(int'(dsx_sc_quad_byte_add) + int'(lo)));
            r.fc  = 1'b1;
            r.own = 1'b1;
         end
         `DSX_ROW_HALVE: begin
            r.own = 1'b1;
            if (lo == 3'h0) begin
               r.sel = bit_of(dsx_sc_halving_add);
               r.fc  = 1'b1;
            end else begin
               r.rsv = 1'b1;
            end
         end
         `DSX_ROW_FOREIGN: begin
            r.rsv = (lo != 3'h0) && (lo != 3'h4);
            r.own = r.rsv;
         end
         `DSX_ROW_RSV: begin
            r.rsv = 1'b1;
            r.own = 1'b1;
         end
         `DSX_ROW_DOT: begin
            r.own = 1'b1;
            r.fc  = 1'b1;
            if (lo == 3'h0) r.sel = bit_of(dsx_sc_word_dot_product);
            else if (lo == 3'h1) r.sel = bit_of(dsx_sc_append);
            else if (lo == 3'h4) r.sel = bit_of(dsx_sc_doubleword_dot_product);
            else begin
               r.fc  = 1'b0;
               r.rsv = 1'b1;
            end
         end
         `DSX_ROW_EXTR: begin
            r.own = (lo != 3'h3);
            r.fc  = 1'b1;
            if (lo == 3'h0) r.sel = bit_of(dsx_sc_word_accumulator_extract);
            else if (lo == 3'h4) r.sel = bit_of(dsx_sc_doubleword_accumulator_extract);
            else begin
               r.fc  = 1'b0;
               r.rsv = (lo != 3'h3);
            end
            if (f == `DSX_FN_DEBUG) begin
               r.rsv = !dbg;
               r.sel = dbg ? bit_of(dsx_sc_debug_support) : '0;
            end
         end
         default: begin
            r = '0;
         end
      endcase
      return r;
   endfunction

   wire dsx_fn_t res = decode_fn(func, debug_present);

   assign sel         = res.sel;
   assign field_class = res.fc;
   assign reserved    = res.rsv;
   assign owned       = res.own;

endmodule

// ==== dsx_decoder.sv ====
// Design decisions made here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`include "dsx_defs.svh"


module dsx_decoder
   import dsx_pkg::*;
(
   // Clock and reset
   input  wire logic                mclk,
   input  wire logic                nrst,
   // Instruction from fetch
   input  wire logic                instr_valid,
   input  wire logic [31:0]         instr,
   // Decode to pipeline
   output dsx_pkg::dsx_dec_t        dec,
   // Avalon-MM slave
   input  wire dsx_pkg::dsx_avs_req_t avs,
   output logic [31:0]              avs_readdata,
   output logic                     avs_waitrequest,
   // Interrupt
   output logic                     irq
);
   import dsx_pkg::*;

   logic [`DSX_CFG_WIDTH-1:0] config_q;
   logic [`DSX_ST_WIDTH-1:0]  status;
   logic [`DSX_ST_WIDTH-1:0]  mask;
   logic [31:0]               fault_instr;
   logic                      ack;

   // Option decode from configuration
   wire logic       rel2      = config_q[`DSX_CFG_REL2];
   wire logic       ext_on    = config_q[`DSX_CFG_EXT];
   wire logic       dbg_on    = config_q[`DSX_CFG_DEBUG];
   wire logic [3:0] cop_ok    = config_q[`DSX_CFG_CU_LSB +: 4];

   // Instruction fields
   wire logic [5:0] major     = instr[31:26];
   wire logic [4:0] target_register_field = instr[20:16];
   wire logic [5:0] func      = instr[5:0];

   wire logic is_third  = (major == `DSX_MAJ_THIRD);
   wire logic is_register_immediate_major_opcode = (major == `DSX_MAJ_REGISTER_IMMEDIATE_MAJOR_OPCODE);
   wire logic is_cop    = (major[5:2] == `DSX_MAJ_COP_HI);

   // Register-immediate target field: row bits 20..19, column bits 18..16
   function automatic logic [1:0] register_immediate_major_opcode_slot(input logic [4:0] rt);
      logic [1:0] r;
      r = 2'h0;
      if (rt[4:3] == `DSX_RT_BPOS_ROW) begin
         if (rt[2:0] == `DSX_RT_BPOS32) r = 2'h1;
         else if (rt[2:0] == `DSX_RT_BPOS64) r = 2'h2;
         else if (rt[2:0] <= 3'h2 || rt[2:0] == 3'h6) r = 2'h3;
      end else if (rt[4:3] != 2'h1 && rt[2]) begin
         r = 2'h3;
      end else if (rt[4:3] == 2'h1 && (rt[2:0] == 3'h5 || rt[2:0] == 3'h7)) begin
         r = 2'h3;
      end
      return r;
   endfunction

   wire logic [1:0] rslot = register_immediate_major_opcode_slot(target_register_field);

   // Function field decode
   dsx_sel_t  fn_sel;
   logic      fn_fc;
   logic      fn_rsv;
   logic      fn_own;

   dsx_fn_decode u_fn (
      .func          (func),
      .debug_present (dbg_on),
      .sel           (fn_sel),
      .field_class   (fn_fc),
      .reserved      (fn_rsv),
      .owned         (fn_own)
   );

   // Branch select
   dsx_sel_t br_sel;
   always_comb begin
      br_sel = '0;
      br_sel[dsx_sc_branch_position_at_least_32] = (rslot == 2'h1);
      br_sel[dsx_sc_branch_position_at_least_64] = (rslot == 2'h2);
   end

   // Ownership and gating
   wire logic third_own  = is_third && fn_own;
   wire logic register_immediate_major_opcode_own = is_register_immediate_major_opcode && (rslot != 2'h0);
   wire logic dsp_slot   = third_own || register_immediate_major_opcode_own;
   wire logic rel1_fault = is_third && !rel2;
   wire logic ext_fault  = dsp_slot && !ext_on;
   wire logic map_fault  = (third_own && fn_rsv) || (register_immediate_major_opcode_own && rslot == 2'h3);
   wire logic cop_fault  = is_cop && !cop_ok[major[1:0]];
   wire logic any_rsv    = rel1_fault || ext_fault || map_fault;
   wire logic sel_ok     = dsp_slot && !any_rsv;
   wire dsx_sel_t raw_sel = is_third ? fn_sel : br_sel;

   // Result in the same cycle the word is valid
   always_comb begin
      dec = '0;
      if (instr_valid) begin
         dec.sel = sel_ok ? raw_sel : '0;
         dec.subclass_selector_field = instr[10:6];
         dec.needs_op = sel_ok && is_third && fn_fc;
         dec.is_dsp = dsp_slot || rel1_fault;
         dec.rsv = any_rsv;
         dec.cop_unusable = cop_fault;
      end
   end

   // Events
   wire logic ev_rsv = instr_valid && any_rsv;
   wire logic ev_cpu = instr_valid && cop_fault;
   wire logic ev_dsp = instr_valid && sel_ok;
   wire logic [`DSX_ST_WIDTH-1:0] events = {ev_dsp, ev_cpu, ev_rsv};

   // Bus decode: one wait state, answer on the second edge
   wire logic req      = avs.read || avs.write;
   wire logic accept   = req && ack;
   wire logic hit_cfg  = (avs.address == `DSX_OFS_CONFIG);
   wire logic hit_st   = (avs.address == `DSX_OFS_STATUS);
   wire logic hit_mask = (avs.address == `DSX_OFS_MASK);
   wire logic hit_flt  = (avs.address == `DSX_OFS_FAULT);
   wire logic wr_cfg   = accept && avs.write && hit_cfg;
   wire logic wr_mask  = accept && avs.write && hit_mask;
   wire logic rd_st    = accept && avs.read && hit_st;

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0;
      if (hit_cfg) rd_mux[`DSX_CFG_WIDTH-1:0] = config_q;
      else if (hit_st) rd_mux[`DSX_ST_WIDTH-1:0] = status;
      else if (hit_mask) rd_mux[`DSX_ST_WIDTH-1:0] = mask;
      else if (hit_flt) rd_mux = fault_instr;
   end

   // Setting wins over the read that clears
   wire logic [`DSX_ST_WIDTH-1:0] next_status = (rd_st ? '0 : status) | events;

   assign avs_waitrequest = req && !ack;
   assign irq = |(status & mask);

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ack <= 1'b0;
      end else begin
         ack <= req && !ack;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         avs_readdata <= 32'h0;
      end else if (req && !ack) begin
         avs_readdata <= rd_mux;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         config_q <= `DSX_CFG_RESET;
      end else if (wr_cfg) begin
         config_q <= avs.writedata[`DSX_CFG_WIDTH-1:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         mask <= `DSX_MASK_RESET;
      end else if (wr_mask) begin
         mask <= avs.writedata[`DSX_ST_WIDTH-1:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         status <= '0;
      end else begin
         status <= next_status;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         fault_instr <= 32'h0;
      end else if (ev_rsv || ev_cpu) begin
         fault_instr <= instr;
      end
   end

   // Checks
   chk_rel1_third_fault: assert property (@(posedge mclk) disable iff (!nrst)
      instr_valid && is_third && !rel2 |-> dec.rsv && dec.sel == '0)
      else $error("third opcode not faulted on first release");

   chk_ext_absent_fault: assert property (@(posedge mclk) disable iff (!nrst)
      instr_valid && is_third && fn_own && !ext_on |-> dec.rsv)
      else $error("extension slot decoded with extension absent");

   chk_sel_onehot_valid: assert property (@(posedge mclk) disable iff (!nrst)
      $onehot0(dec.sel) && (!dec.rsv || dec.sel == '0)
      && (instr_valid || dec == '0))
      else $error("select not one-hot or present with fault");

   chk_misc_row_rsv: assert property (@(posedge mclk) disable iff (!nrst)
      instr_valid && is_third && func[5:3] == 3'h1 && (func[2:0] == 3'h3 || func[2:0] >= 3'h6)
      |-> dec.rsv)
      else $error("reserved misc slot not faulted");

   chk_row_five_rsv: assert property (@(posedge mclk) disable iff (!nrst)
      instr_valid && is_third && func[5:3] == 3'h5 |-> dec.rsv)
      else $error("row 101 not faulted");

   chk_bpos_decode: assert property (@(posedge mclk) disable iff (!nrst)
      instr_valid && is_register_immediate_major_opcode && ext_on && target_register_field == 5'h1c
      |-> dec.sel[dsx_sc_branch_position_at_least_32] && !dec.rsv)
      else $error("position branch 32 not decoded");

   chk_op_field_pass: assert property (@(posedge mclk) disable iff (!nrst)
      instr_valid |-> dec.subclass_selector_field == instr[10:6])
      else $error("op field not passed through");

   chk_arith_row_sel: assert property (@(posedge mclk) disable iff (!nrst)
      instr_valid && is_third && rel2 && ext_on && func[5:3] == 3'h2
      |-> dec.sel[int'(dsx_sc_quad_byte_add) + int'(func[2:0])] && dec.needs_op)
      else $error("arithmetic row class wrong");

   chk_cop_unusable: assert property (@(posedge mclk) disable iff (!nrst)
      instr_valid && is_cop |-> dec.cop_unusable == !cop_ok[major[1:0]])
      else $error("coprocessor unusable flag wrong");

   chk_debug_slot: assert property (@(posedge mclk) disable iff (!nrst)
      instr_valid && is_third && rel2 && ext_on && func == `DSX_FN_DEBUG
      |-> dec.rsv == !dbg_on)
      else $error("debug slot handling wrong");

   chk_status_sticky: assert property (@(posedge mclk) disable iff (!nrst)
      ev_rsv |=> status[`DSX_ST_RSV] && fault_instr == $past(instr))
      else $error("reserved event not recorded");

   chk_bus_one_wait: assert property (@(posedge mclk) disable iff (!nrst)
      $rose(req) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("bus answer not after one wait state");

endmodule

// ==== dsx_fetch_model.sv ====
`timescale 1ns/1ps

module dsx_fetch_model (
   // Clock
   input  wire logic        mclk,
   // Instruction to decoder
   output logic             instr_valid,
   output logic [31:0]      instr
);
   logic        live;
   logic [31:0] word;

   initial begin
      live = 1'b0;
      word = 32'h0;
      instr_valid = 1'b0;
      instr = 32'h0;
   end

   // Idle word flips each cycle so a stale word never looks live
   always @(posedge mclk) begin
      instr_valid <= live;
      instr <= live ? word : ~instr;
   end

   // Words go out as given; the stream never relies on obsolete codes
   task automatic issue(input logic [31:0] w);
      word = w;
      live = 1'b1;
      @(posedge mclk);
   endtask

   task automatic stop();
      live = 1'b0;
      @(posedge mclk);
   endtask
endmodule

// ==== dsp_extension_opcode_decoder_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin errors++; \
   $display("Error %0t: got %h expected %h", $time, got, exp); end end

module dsp_extension_opcode_decoder_tb_top;
   import dsx_pkg::*;

   logic         mclk;
   logic         nrst;
   logic         instr_valid;
   logic [31:0]  instr;
   dsx_dec_t     dec;
   dsx_avs_req_t avs;
   logic [31:0]  avs_readdata;
   logic         avs_waitrequest;
   logic         irq;
   int           errors;
   int           comparisons;
   int           seed;
   logic [7:0]   cfg;
   logic [31:0]  rd;
   logic [31:0]  r;
   logic [7:0]   cfgs [5];

   // Function-field map: -1 other instruction, -2 reserved, else sub-class index
   localparam int FMAP [64] = '{-1,-1,-1,-1,-1,-1,-1,-1, -1,-1,0,-2,1,2,-2,-2,
      3,4,5,6,7,8,9,10, 11,-2,-2,-2,-2,-2,-2,-2, -1,-2,-2,-2,-1,-2,-2,-2,
      -2,-2,-2,-2,-2,-2,-2,-2, 12,13,-2,-2,14,-2,-2,-2, 15,-2,-2,-1,16,-2,-2,19};
   localparam logic [31:0] RT_RSV = 32'h47f0a0f0;

   dsx_decoder uut (
      .mclk            (mclk),
      .nrst            (nrst),
      .instr_valid     (instr_valid),
      .instr           (instr),
      .dec             (dec),
      .avs             (avs),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest),
      .irq             (irq)
   );

   dsx_fetch_model fetch (
      .mclk        (mclk),
      .instr_valid (instr_valid),
      .instr       (instr)
   );

   always #4 mclk = ~mclk;

   function automatic dsx_dec_t exp_dec(input logic [31:0] w, input logic [7:0] c);
      int       k;
      dsx_dec_t e;
      e = '0;
      k = -1;
      e.subclass_selector_field = w[10:6];
      if (w[31:26] == 6'h1f) begin
         k = FMAP[w[5:0]];
         e.is_dsp = 1'b1;
         if (!c[0]) k = -2;
         else if (k == -1) e.is_dsp = 1'b0;
         else if (!c[1]) k = -2;
         else if (k == 19) k = c[2] ? 19 : -2;
      end else if (w[31:26] == 6'h01) begin
         e.is_dsp = RT_RSV[w[20:16]] || w[20:17] == 4'he;
         if (w[20:17] == 4'he) k = c[1] ? 17 + w[16] : -2;
         else if (RT_RSV[w[20:16]]) k = -2;
      end else if (w[31:28] == 4'h4) begin
         e.cop_unusable = !c[4 + w[27:26]];
      end
      if (k >= 0) begin
         e.sel[k] = 1'b1;
         e.needs_op = !(k inside {1, 2, 17, 18, 19});
      end else if (k == -2) begin
         e.rsv = 1'b1;
      end
      return e;
   endfunction

   // Request held until waitrequest is sampled low; data taken at that edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge mclk);
      avs <= {~wr, wr, a, d};
      @(posedge mclk iff avs_waitrequest === 1'b0);
      q = avs_readdata;
      avs <= '0;
   endtask

   task automatic set_cfg(input logic [7:0] c);
      fetch.stop();
      bus(1'b1, 4'h0, {24'h0, c}, rd);
      bus(1'b0, 4'h0, 32'h0, rd);
      `CHK(rd, {24'h0, c})
      cfg = c;
   endtask

   task automatic check_word(input logic [31:0] w);
      dsx_dec_t e;
      fetch.issue(w);
      @(negedge mclk);
      e = exp_dec(w, cfg);
      `CHK(dec.sel, e.sel)
      `CHK(dec.subclass_selector_field, e.subclass_selector_field)
      `CHK(dec.needs_op, e.needs_op)
      `CHK(dec.rsv, e.rsv)
      `CHK(dec.cop_unusable, e.cop_unusable)
      `CHK(dec.is_dsp, e.is_dsp)
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      $display("Error %0t: watchdog expired", $time);
      report_and_stop();
   end

   initial begin
      mclk = 1'b0;
      nrst = 1'b0;
      avs = '0;
      errors = 0;
      comparisons = 0;
      seed = 32'hddb27bbf;
      cfg = 8'h13;
      cfgs = '{8'h13, 8'h12, 8'h11, 8'h17, 8'hf3};
      repeat (8) @(posedge mclk);
      nrst <= 1'b1;
      bus(1'b0, 4'h0, 32'h0, rd);
      `CHK(rd, 32'h13)
      for (int a = 4; a < 16; a += 4) begin
         bus(1'b0, a[3:0], 32'h0, rd);
         `CHK(rd, 32'h0)
      end
      bus(1'b1, 4'h1, 32'hffffffff, rd);
      bus(1'b0, 4'h1, 32'h0, rd);
      `CHK(rd, 32'h0)
      $display("test registers done");
      foreach (cfgs[i]) begin
         set_cfg(cfgs[i]);
         for (int f = 0; f < 64; f++) begin
            r = $random(seed);
            check_word({6'h1f, r[25:6], f[5:0]});
         end
         for (int t = 0; t < 32; t++) begin
            r = $random(seed);
            check_word({6'h01, r[25:21], t[4:0], r[15:0]});
         end
         for (int z = 0; z < 4; z++) begin
            r = $random(seed);
            check_word({4'h4, z[1:0], r[25:0]});
         end
      end
      $display("test sweep done");
      set_cfg(8'h13);
      bus(1'b1, 4'h8, 32'h1, rd);
      bus(1'b0, 4'h4, 32'h0, rd);
      check_word(32'h7c00_002b);
      fetch.stop();
      @(negedge mclk);
      `CHK(irq, 1'b1)
      bus(1'b0, 4'h4, 32'h0, rd);
      `CHK(rd[2:0], 3'b001)
      bus(1'b0, 4'hc, 32'h0, rd);
      `CHK(rd, 32'h7c00_002b)
      @(negedge mclk);
      `CHK(irq, 1'b0)
      bus(1'b1, 4'h8, 32'h0, rd);
      check_word(32'h4400_0000);
      fetch.stop();
      @(negedge mclk);
      `CHK(irq, 1'b0)
      bus(1'b0, 4'h4, 32'h0, rd);
      `CHK(rd[2:0], 3'b010)
      bus(1'b0, 4'hc, 32'h0, rd);
      `CHK(rd, 32'h4400_0000)
      check_word(32'h7c00_0010);
      fetch.stop();
      bus(1'b0, 4'h4, 32'h0, rd);
      `CHK(rd[2:0], 3'b100)
      $display("test interrupt done");
      for (int i = 0; i < 1500; i++) begin
         if (i % 100 == 0) begin
            r = $random(seed);
            set_cfg(r[7:0] & 8'hf7);
         end
         r = $random(seed);
         case (i % 4)
            0: check_word({6'h1f, r[25:0]});
            1: check_word({6'h01, r[25:0]});
            2: check_word({4'h4, r[27:0]});
            default: check_word(r);
         endcase
      end
      fetch.stop();
      @(negedge mclk);
      `CHK(dec, dsx_dec_t'(0))
      $display("test random done");
      report_and_stop();
   end
endmodule
